// ### va_region_defs.vh
// Field positions, region codes and cachability codes for the region decoder
`ifndef VA_REGION_DEFS_VH
`define VA_REGION_DEFS_VH
`define VA_REGION_HI      63
`define VA_REGION_LO      62
`define VA_FILLER_HI      61
`define VA_FILLER_LO      48
`define VA_PAGE_HI        47
`define VA_CACHE_HI       61
`define VA_CACHE_LO       59
`define VA_KP_ZERO_HI     58
`define VA_KP_ZERO_LO     40
`define PA_HI             39
`define REGION_USER       2'b00
`define REGION_KPRIVATE   2'b01
`define REGION_KDIRECT    2'b10
`define REGION_KGLOBAL    2'b11
`define CACHE_EXCL_WRITE  3'b101
`define CACHE_EXCL        3'b100
`define CACHE_NONCOH      3'b011
`define CACHE_UNC_SEQ     3'b010
`define CACHE_UNC_COP     3'b000
`define FILLER_ZERO       14'h0000
`define FILLER_ONES       14'h3fff
`define KP_ZERO_FIELD     19'h00000
`define SPACE_ID_W        8
`endif

// ### fetch_id_compare.v
// Fetch cache space identifier compare stage
`timescale 1ns/1ps
module fetch_id_compare (
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  input  wire       fetch_valid_i,
  input  wire [7:0] fetch_space_identifier_i,
  input  wire [7:0] fetch_tag_space_identifier_i,
  output reg        fetch_id_match_o
);
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_id_match_o <= 1'b0;
    end else begin
      fetch_id_match_o <= fetch_valid_i &&
        (fetch_space_identifier_i == fetch_tag_space_identifier_i);
    end
  end
endmodule // fetch_id_compare

// ### virtual_address_region_decoder.v
// Virtual address region decoder with privilege and filler checks
`timescale 1ns/1ps
`include "va_region_defs.vh"
// Notes on behaviour
// - An address splits into region 63:62, filler 61:48 and page+offset 47:0.
// - Region 00 is user, 01 kernel private, 10 kernel direct, 11 kernel global.
// - Only kernel and user privilege exist.
// - In user mode any region other than 00 is an address error.
// - User and kernel private addresses with nonzero filler are errors.
// - Kernel global accepts all-zero or all-one filler as the same address.
// - User and kernel private translate via TLB with the translation id.
// - Kernel global translates via TLB with no space identifier.
// - Kernel direct bypasses the TLB; physical 39:0 equals virtual 39:0.
// - Kernel direct cachability comes from filler bits 61:59.
// - Kernel direct codes outside the five sub-ranges are errors.
// - Translated regions take coherency from the matching TLB entry.
// - TLB compares translation id with entry tag, independent of fetch id.
// - Kernel mode, base register zero, negative offset forces region 11.
module virtual_address_region_decoder (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        lookup_valid_i,
  input  wire [63:0] virtual_address_i,
  input  wire        kernel_mode_i,
  input  wire        base_is_zero_reg_i,
  input  wire        offset_negative_i,
  input  wire [7:0]  translation_space_identifier_i,
  input  wire [7:0]  entry_space_identifier_i,
  input  wire [2:0]  entry_coherency_i,
  input  wire        fetch_valid_i,
  input  wire [7:0]  fetch_space_identifier_i,
  input  wire [7:0]  fetch_tag_space_identifier_i,
  output reg         lookup_valid_o,
  output reg         address_error_o,
  output reg  [1:0]  region_o,
  output reg         use_tlb_o,
  output reg         use_space_id_o,
  output reg  [7:0]  space_identifier_o,
  output reg  [47:0] virtual_page_number_o,
  output reg         tlb_id_match_o,
  output reg  [39:0] physical_address_o,
  output reg  [2:0]  coherency_o,
  output wire        fetch_id_match_o
);
  // Legal cachability code within kernel direct space
  function cache_code_ok;
    input [2:0] code;
    begin
      case (code)
        `CACHE_EXCL_WRITE, `CACHE_EXCL, `CACHE_NONCOH,
        `CACHE_UNC_SEQ, `CACHE_UNC_COP: cache_code_ok = 1'b1;
        default: cache_code_ok = 1'b0;
      endcase
    end
  endfunction

  // Regions that are looked up in the translation buffer
  function region_uses_tlb;
    input [1:0] region;
    begin
      case (region)
        `REGION_USER, `REGION_KPRIVATE,
        `REGION_KGLOBAL: region_uses_tlb = 1'b1;
        default: region_uses_tlb = 1'b0;
      endcase
    end
  endfunction

  // Regions whose address is extended with the translation id
  function region_uses_id;
    input [1:0] region;
    begin
      case (region)
        `REGION_USER, `REGION_KPRIVATE: region_uses_id = 1'b1;
        default: region_uses_id = 1'b0;
      endcase
    end
  endfunction

  localparam FILLER_W = `VA_FILLER_HI - `VA_FILLER_LO + 1;
  localparam HIGH_W   = `VA_KP_ZERO_HI - `VA_KP_ZERO_LO + 1;

  reg  [1:0]  region_next;
  reg         error_next;
  reg         tlb_next;
  reg         space_identifier_next;
  reg  [2:0]  coh_next;
  reg         err_priv;
  reg         err_filler;
  reg         err_global;
  reg         err_code;
  reg         err_high;
  wire [13:0] filler = virtual_address_i[`VA_FILLER_HI:`VA_FILLER_LO];
  wire [47:0] page = virtual_address_i[`VA_PAGE_HI:0];
  wire [2:0]  direct_code = virtual_address_i[`VA_CACHE_HI:`VA_CACHE_LO];
  wire [18:0] direct_high = virtual_address_i[`VA_KP_ZERO_HI:`VA_KP_ZERO_LO];
  wire        force_global = kernel_mode_i && base_is_zero_reg_i &&
                             offset_negative_i;
  wire [13:0] filler_any;
  wire [13:0] filler_all;
  wire [18:0] high_any;
  wire        filler_zero;
  wire        filler_ones;
  wire        lookup_ok;
  genvar      fb;
  genvar      hb;

  // Running OR and AND over the filler, lowest bit first
  generate
    for (fb = 0; fb < FILLER_W; fb = fb + 1) begin : g_filler
      if (fb == 0) begin : g_first
        assign filler_any[fb] = filler[fb];
        assign filler_all[fb] = filler[fb];
      end else begin : g_chain
        assign filler_any[fb] = filler_any[fb-1] | filler[fb];
        assign filler_all[fb] = filler_all[fb-1] & filler[fb];
      end
    end
  endgenerate
  assign filler_zero = !filler_any[FILLER_W-1];
  assign filler_ones = filler_all[FILLER_W-1];

  // Same chain over the bits that must stay clear in kernel direct space
  generate
    for (hb = 0; hb < HIGH_W; hb = hb + 1) begin : g_high
      if (hb == 0) begin : g_first
        assign high_any[hb] = direct_high[hb];
      end else begin : g_chain
        assign high_any[hb] = high_any[hb-1] | direct_high[hb];
      end
    end
  endgenerate

  // Alignment and base-region checks stay with the address generator
  always @* begin
    region_next = virtual_address_i[`VA_REGION_HI:`VA_REGION_LO];
    // Kernel-only forcing; user keeps its bits so the check below trips
    if (force_global) begin
      region_next = `REGION_KGLOBAL;
    end
    err_priv   = 1'b0;
    err_filler = 1'b0;
    err_global = 1'b0;
    err_code   = 1'b0;
    err_high   = 1'b0;
    coh_next   = entry_coherency_i;
    case (region_next)
      `REGION_USER, `REGION_KPRIVATE: begin
        err_filler = !filler_zero;
      end
      `REGION_KGLOBAL: begin
        // Both filler forms name one address, a mix names none
        err_global = !filler_zero && !filler_ones;
      end
      `REGION_KDIRECT: begin
        coh_next = direct_code;
        err_code = !cache_code_ok(direct_code);
        err_high = high_any[HIGH_W-1];
      end
      default: err_code = 1'b1;
    endcase
    // Only two privilege levels: user may touch region 00 alone
    if (!kernel_mode_i && (region_next != `REGION_USER)) begin
      err_priv = 1'b1;
    end
    error_next = err_priv   ||
                 err_filler ||
                 err_global ||
                 err_code   ||
                 err_high;
    tlb_next   = region_uses_tlb(region_next);
    space_identifier_next  = region_uses_id(region_next);
  end

  // An erroring lookup must reach neither the buffer nor the space id use; the tlb_id_match_o compare is not gated
  assign lookup_ok = lookup_valid_i && !error_next;

  // Qualifier and error flags
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lookup_valid_o  <= 1'b0;
      address_error_o <= 1'b0;
      use_tlb_o       <= 1'b0;
      use_space_id_o  <= 1'b0;
      tlb_id_match_o  <= 1'b0;
    end else begin
      lookup_valid_o  <= lookup_valid_i;
      // Error flagged alongside the lookup result, same cycle
      address_error_o <= lookup_valid_i && error_next;
      use_tlb_o       <= lookup_ok && tlb_next;
      use_space_id_o  <= lookup_ok && space_identifier_next;
      tlb_id_match_o  <= !space_identifier_next ||
        (translation_space_identifier_i == entry_space_identifier_i);
    end
  end

  // Address, id and attribute fields; loaded every edge, valid or not
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      region_o              <= `REGION_USER;
      space_identifier_o    <= 8'h00;
      virtual_page_number_o <= 48'h0;
      physical_address_o    <= 40'h0;
      coherency_o           <= 3'h0;
    end else begin
      region_o              <= region_next;
      space_identifier_o    <= space_identifier_next ?
                               translation_space_identifier_i : 8'h00;
      // Both kernel global filler forms yield the same page number
      virtual_page_number_o <= page;
      physical_address_o    <= virtual_address_i[`PA_HI:0];
      coherency_o           <= coh_next;
    end
  end

  fetch_id_compare u_fetch_id_compare (
    .sys_clk_i                    (sys_clk_i),
    .sys_rst_i                    (sys_rst_i),
    .fetch_valid_i                (fetch_valid_i),
    .fetch_space_identifier_i     (fetch_space_identifier_i),
    .fetch_tag_space_identifier_i (fetch_tag_space_identifier_i),
    .fetch_id_match_o             (fetch_id_match_o)
  );
endmodule // virtual_address_region_decoder

// ### region_decoder_props.sv
// Checker for the region decoder outputs
`timescale 1ns/1ps
module region_decoder_props (
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        lookup_valid_i,
  input wire [63:0] virtual_address_i,
  input wire        kernel_mode_i,
  input wire        base_is_zero_reg_i,
  input wire        offset_negative_i,
  input wire [2:0]  entry_coherency_i,
  input wire        fetch_valid_i,
  input wire [7:0]  fetch_space_identifier_i,
  input wire [7:0]  fetch_tag_space_identifier_i,
  input wire        address_error_o,
  input wire        use_tlb_o,
  input wire        use_space_id_o,
  input wire [39:0] physical_address_o,
  input wire [2:0]  coherency_o,
  input wire [1:0]  region_o,
  input wire        fetch_id_match_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // A positive offset can never force the region
  wire        r = lookup_valid_i & ~offset_negative_i;
  wire        k = kernel_mode_i;
  wire [1:0]  g = virtual_address_i[63:62];
  wire [13:0] f = virtual_address_i[61:48];
  wire [2:0]  c = virtual_address_i[61:59];
  wire [39:0] low = virtual_address_i[39:0];
  property p_user; r && !k && g != 2'h0 |=> address_error_o; endproperty
  a_user: assert property (p_user) else $error("user region");
  property p_fill; r && !g[1] && f != 14'h0 |=> address_error_o; endproperty
  a_fill: assert property (p_fill) else $error("filler");
  property p_code; r && g == 2'h2 && (c == 3'h1 || c > 3'h5) |=>
    address_error_o; endproperty
  a_code: assert property (p_code) else $error("direct code");
  property p_zero; r && g == 2'h2 && |virtual_address_i[58:40] |=>
    address_error_o; endproperty
  a_zero: assert property (p_zero) else $error("direct high");
  property p_pa; r && g == 2'h2 |=> !use_tlb_o &&
    physical_address_o == $past(low); endproperty
  a_pa: assert property (p_pa) else $error("direct address");
  property p_coh; r |=> coherency_o ==
    ($past(g) == 2'h2 ? $past(c) : $past(entry_coherency_i)); endproperty
  a_coh: assert property (p_coh) else $error("coherency");
  property p_glob; r && k && g == 2'h3 && (f == 14'h0 || &f) |=>
    use_tlb_o && !use_space_id_o && !address_error_o; endproperty
  a_glob: assert property (p_glob) else $error("global");
  property p_id; r && k && !g[1] && f == 14'h0 |=> use_tlb_o && use_space_id_o;
  endproperty
  a_id: assert property (p_id) else $error("space id");
  property p_force; lookup_valid_i && k && base_is_zero_reg_i &&
    offset_negative_i |=> region_o == 2'h3; endproperty
  a_force: assert property (p_force) else $error("forced region");
  property p_fetch; fetch_valid_i &&
    fetch_space_identifier_i == fetch_tag_space_identifier_i |=>
    fetch_id_match_o; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch id match");
  property p_nofetch; !fetch_valid_i |=> !fetch_id_match_o; endproperty
  a_nofetch: assert property (p_nofetch) else $error("fetch idle");
endmodule // region_decoder_props
bind virtual_address_region_decoder region_decoder_props u_props (
  .sys_clk_i                    (sys_clk_i),
  .sys_rst_i                    (sys_rst_i),
  .lookup_valid_i               (lookup_valid_i),
  .virtual_address_i            (virtual_address_i),
  .kernel_mode_i                (kernel_mode_i),
  .base_is_zero_reg_i           (base_is_zero_reg_i),
  .offset_negative_i            (offset_negative_i),
  .entry_coherency_i            (entry_coherency_i),
  .fetch_valid_i                (fetch_valid_i),
  .fetch_space_identifier_i     (fetch_space_identifier_i),
  .fetch_tag_space_identifier_i (fetch_tag_space_identifier_i),
  .address_error_o              (address_error_o),
  .use_tlb_o                    (use_tlb_o),
  .use_space_id_o               (use_space_id_o),
  .physical_address_o           (physical_address_o),
  .coherency_o                  (coherency_o),
  .region_o                     (region_o),
  .fetch_id_match_o             (fetch_id_match_o)
);

// ### far_side_model.sv
// Translation buffer entry seen by the decoder
`timescale 1ns/1ps
module far_side_model (
  input  wire [7:0] key_i,
  input  wire       hit_i,
  input  wire [7:0] page_i,
  output wire [7:0] entry_id_o,
  output wire [2:0] entry_coh_o
);
  // A miss differs in every bit so a stuck compare shows
  assign entry_id_o  = hit_i ? key_i : ~key_i;
  assign entry_coh_o = page_i[2:0];
endmodule // far_side_model

// ### tb_top.sv
// Self-checking bench for the region decoder
`timescale 1ns/1ps
module tb_top;
  reg         clk = 0, rst = 1, k = 0, bz = 0, ng = 0, hit = 0, lv = 0, fv = 0;
  reg  [63:0] va = 0;
  reg  [7:0]  tid = 0, fid = 0, ft = 0;
  wire [7:0]  eid, sid;
  wire [2:0]  ec, coh;
  wire [1:0]  rg;
  wire [47:0] virtual_page_number;
  wire [39:0] pa;
  wire        vo, err, ut, us, tm, fm;
  integer     bad_count = 0, total_checks = 0, i;
  reg  [63:0] tab [0:7] = '{64'h1000, 64'h4000_0000_0000_0000,
    64'h1_0000_0000_0000, 64'hffff_1234_5678_9abc, 64'hc000_0000_0000_0040,
    64'hc100_0000_0000_0000, 64'h8000_2000_0000_0000, 64'hffff_ffff_ffff_fff0};
  always #4 clk = ~clk;
  far_side_model tlb (.key_i(tid), .hit_i(hit), .page_i(va[7:0]),
    .entry_id_o(eid), .entry_coh_o(ec));
  virtual_address_region_decoder dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .lookup_valid_i(lv), .virtual_address_i(va), .kernel_mode_i(k),
    .base_is_zero_reg_i(bz), .offset_negative_i(ng),
    .translation_space_identifier_i(tid), .entry_space_identifier_i(eid),
    .entry_coherency_i(ec), .fetch_valid_i(fv),
    .fetch_space_identifier_i(fid), .fetch_tag_space_identifier_i(ft),
    .lookup_valid_o(vo), .address_error_o(err), .region_o(rg),
    .use_tlb_o(ut), .use_space_id_o(us), .space_identifier_o(sid),
    .virtual_page_number_o(virtual_page_number), .tlb_id_match_o(tm),
    .physical_address_o(pa), .coherency_o(coh), .fetch_id_match_o(fm));
  task chk(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task look(input [63:0] a, input kk, input z, input n);
    integer e, g, f;
    begin
      va  = a;
      k   = kk;
      bz  = z;
      ng  = n;
      lv  = ($urandom % 8) != 0;
      fv  = ($urandom % 8) != 0;
      tid = $urandom;
      fid = $urandom;
      hit = $urandom;
      ft  = hit ? fid : tid;
      g = (kk && z && n) ? 3 : a[63:62];
      f = a[61:48];
      e = (!kk && a[63:62] != 0) || (g < 2 && f != 0) ||
        (g == 3 && f != 0 && f != 16383) ||
        (g == 2 && (a[61:59] == 1 || a[61:59] > 5 || a[58:40] != 0));
      @(negedge clk);
      chk(err, lv && e);
      chk({vo, rg, virtual_page_number}, {lv, g[1:0], a[47:0]});
      chk({ut, us}, {lv && !e && g != 2, lv && !e && g < 2});
      chk(sid, g < 2 ? tid : 0);
      chk(coh, g == 2 ? a[61:59] : ec);
      if (g == 2) chk(pa, a[39:0]);
      if (!e) chk(tm, g > 1 || eid == tid);
      chk(fm, fv && fid == ft);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    i = $urandom(32'h134c6546);
    repeat (10) @(negedge clk);
    rst = 0;
    for (i = 0; i < 16; i = i + 1) look(tab[i/2], i % 2, 0, 0);
    $display("region table done");
    for (i = 0; i < 8; i = i + 1)
      look({2'h2, i[2:0], 19'h0, 40'h12_3456_7890}, 1, 0, 0);
    look(64'h0000_ffff_ffff_fff0, 1, 1, 1);
    look(64'h4000_0000_0000_0000, 0, 1, 1);
    $display("direct codes and forcing done");
    repeat (40) look({$urandom, $urandom} & 64'hc000_ffff_ffff_ffff,
      $urandom, $urandom, $urandom);
    repeat (24) look({$urandom, $urandom}, $urandom, $urandom, $urandom);
    $display("random lookups done");
    report_and_stop;
  end
endmodule // tb_top
